//--- src/front_panel_controller.sv
// Front panel controller of the scan converter: button navigation, the
// settings behind each panel control, the selection region and all LEDs.
// Assumes all inputs are synchronous to ref_clk; raster size comes from the
// input detector, timing offset from the software control path.
// Operation
// - Prev and next step the selected control through the control list.
// - The selected control's LED blinks for as long as it stays selected.
// - Right advances or increments the selected control; left steps back.
// - Left and right held together restore the selected control's default, only its horizontal part on position and size.
// - On position, left+right zero horizontal; up+down zero vertical position.
// - Control LED green at default value, orange otherwise.
// - A held arrow repeats its step, faster the longer it is held.
// - Input type auto-detected by default, or forced digital or analog.
// - Standard toggles 60 Hz NTSC and 50 Hz PAL; active LED green.
// - Mode cycles SD, 1080i, 720p; active mode LED green.
// - Input-valid LED green only while valid video is detected.
// - Reference LED green only when reference is valid and locked.
// - Position is upper-left, size lower-right corner; arrows move them.
// - Up+left+right on position or size maximizes keeping a 16:9 or 4:3 ratio; manual fills the raster.
// - Aspect 16:9, 4:3 or manual; pillar or letter boxes fit output.
// - Sharpness runs 1 to 8, starting at 4, selecting filter sets.
// - Bars on gives color bars and 1 kHz tone; off passes video.
// - Composite copies SD output in SD mode, shows black in HD.
// - Outputs zero-timed to reference by default, offset adjustable.
// - Border sets width of black frame around the picture.
// - Panel lock makes the device ignore every button action.
`timescale 1ns/1ps
`default_nettype none
module front_panel_controller import panel_pkg::*; #(
  parameter int DEB_CYC = DEBOUNCE_CYC,
  parameter int WIN_CYC = COINCIDE_CYC,
  parameter int BLK_CYC = BLINK_CYC,
  parameter int FIRST_CYC = RPT_FIRST_CYC,
  parameter int SLOW_CYC = RPT_SLOW_CYC,
  parameter int FAST_CYC = RPT_FAST_CYC,
  parameter int OFS_W = 20
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [NUM_BTN-1:0] btn_raw,
  input wire logic panel_locked,
  input wire logic in_valid,
  input wire logic in_digital,
  input wire logic [COORD_W-1:0] raster_w,
  input wire logic [COORD_W-1:0] raster_h,
  input wire logic ref_valid,
  input wire logic ref_locked,
  input wire logic [OFS_W-1:0] timing_offset,
  output logic [NUM_CTL-1:0] ctl_led_green,
  output logic [NUM_CTL-1:0] ctl_led_orange,
  output logic led_digital,
  output logic led_analog,
  output logic led_ntsc,
  output logic led_pal,
  output logic [2:0] led_mode,
  output logic led_in_valid,
  output logic led_ref,
  output settings_s settings,
  output region_s region,
  output logic pillar_box,
  output logic letter_box,
  output logic sdi_bars,
  output logic tone_1k_en,
  output logic cvbs_copy_sd,
  output logic cvbs_black,
  output logic genlock_en,
  output logic [OFS_W-1:0] out_offset
);

  typedef struct packed {
    logic [3:0] ctl;
    settings_s set;
    region_s reg_r;
    logic [CNT_W-1:0] blink_cnt;
    logic blink_on;
    logic [NUM_CTL-1:0] green;
    logic [NUM_CTL-1:0] orange;
    logic dig;
    logic ana;
    logic ntsc;
    logic pal;
    logic [2:0] mode_led;
    logic inv;
    logic refl;
    logic pillar;
    logic letter;
    logic genlock;
    logic [OFS_W-1:0] ofs;
  } fp_state_s;

  fp_state_s s_q;
  fp_state_s s_d;
  logic [NUM_BTN-1:0] btn_lvl;
  action_s act_raw;
  action_s act;
  logic [COORD_W-1:0] rw;
  logic [COORD_W-1:0] rh;
  logic [COORD_W-1:0] mw;
  logic [COORD_W-1:0] mh;
  logic [COORD_W+3:0] tmp;
  logic [NUM_CTL-1:0] dflt;
  logic hd;

  button_debounce #(
    .N(NUM_BTN),
    .DEB_CYC(DEB_CYC)
  ) u_deb (
    .ref_clk(ref_clk),
    .rst(rst),
    .raw(btn_raw),
    .level(btn_lvl)
  );

  press_engine #(
    .WIN_CYC(WIN_CYC),
    .FIRST_CYC(FIRST_CYC),
    .SLOW_CYC(SLOW_CYC),
    .FAST_CYC(FAST_CYC)
  ) u_press (
    .ref_clk(ref_clk),
    .rst(rst),
    .btn(btn_lvl),
    .act(act_raw)
  );

  // A raster under two pixels would leave no room for two corners.
  assign rw = (raster_w < 12'h002) ? 12'h002 : raster_w;
  assign rh = (raster_h < 12'h002) ? 12'h002 : raster_h;
  assign act = panel_locked ? '0 : act_raw;

  // Largest region for the current aspect that fits the raster.
  always_comb begin
    mw = rw;
    mh = rh;
    tmp = '0;
    if (s_q.set.aspect == ASP_16X9) begin
      tmp = ({4'h0, rw} * 16'd9) >> 4;
      if (tmp[COORD_W-1:0] <= rh) begin
        mh = tmp[COORD_W-1:0];
      end else begin
        tmp = ({4'h0, rh} * 16'd16) / 16'd9;
        mw = tmp[COORD_W-1:0];
      end
    end else if (s_q.set.aspect == ASP_4X3) begin
      tmp = ({4'h0, rw} * 16'd3) >> 2;
      if (tmp[COORD_W-1:0] <= rh) begin
        mh = tmp[COORD_W-1:0];
      end else begin
        tmp = ({4'h0, rh} * 16'd4) / 16'd3;
        mw = tmp[COORD_W-1:0];
      end
    end
  end

  always_comb begin
    s_d = s_q;
    if (act.prev) begin
      s_d.ctl = (s_q.ctl == CTL_INPUT) ? CTL_LAST : s_q.ctl - 1'b1;
    end else if (act.next) begin
      s_d.ctl = (s_q.ctl == CTL_LAST) ? CTL_INPUT : s_q.ctl + 1'b1;
    end
    case (s_q.ctl)
      CTL_INPUT: begin
        if (act.right) begin
          s_d.set.input_sel = (s_q.set.input_sel == IN_ANALOG) ? IN_AUTO :
                              input_sel_e'(s_q.set.input_sel + 2'h1);
        end else if (act.left) begin
          s_d.set.input_sel = (s_q.set.input_sel == IN_AUTO) ? IN_ANALOG :
                              input_sel_e'(s_q.set.input_sel - 2'h1);
        end else if (act.def_h) begin
          s_d.set.input_sel = IN_AUTO;
        end
      end
      CTL_STD: begin
        if (act.right || act.left) begin
          s_d.set.std_pal = ~s_q.set.std_pal;
        end else if (act.def_h) begin
          s_d.set.std_pal = STD_PAL_RST;
        end
      end
      CTL_MODE: begin
        if (act.right) begin
          s_d.set.mode = (s_q.set.mode == MODE_720P) ? MODE_SD :
                         out_mode_e'(s_q.set.mode + 2'h1);
        end else if (act.left) begin
          s_d.set.mode = (s_q.set.mode == MODE_SD) ? MODE_720P :
                         out_mode_e'(s_q.set.mode - 2'h1);
        end else if (act.def_h) begin
          s_d.set.mode = MODE_SD;
        end
      end
      CTL_POS: begin
        if (act.left && s_q.reg_r.x0 != COORD_ZERO) begin
          s_d.reg_r.x0 = s_q.reg_r.x0 - 1'b1;
        end else if (act.right) begin
          s_d.reg_r.x0 = s_q.reg_r.x0 + 1'b1;
        end else if (act.up && s_q.reg_r.y0 != COORD_ZERO) begin
          s_d.reg_r.y0 = s_q.reg_r.y0 - 1'b1;
        end else if (act.down) begin
          s_d.reg_r.y0 = s_q.reg_r.y0 + 1'b1;
        end else if (act.def_h) begin
          s_d.reg_r.x0 = COORD_ZERO;
        end else if (act.def_v) begin
          s_d.reg_r.y0 = COORD_ZERO;
        end
      end
      CTL_SIZE: begin
        if (act.left && s_q.reg_r.x1 > 12'h001) begin
          s_d.reg_r.x1 = s_q.reg_r.x1 - 1'b1;
        end else if (act.right && s_q.reg_r.x1 != COORD_MAX) begin
          s_d.reg_r.x1 = s_q.reg_r.x1 + 1'b1;
        end else if (act.up && s_q.reg_r.y1 > 12'h001) begin
          s_d.reg_r.y1 = s_q.reg_r.y1 - 1'b1;
        end else if (act.down && s_q.reg_r.y1 != COORD_MAX) begin
          s_d.reg_r.y1 = s_q.reg_r.y1 + 1'b1;
        end else if (act.def_h) begin
          s_d.reg_r.x1 = rw - 1'b1;
        end else if (act.def_v) begin
          s_d.reg_r.y1 = rh - 1'b1;
        end
      end
      CTL_ASPECT: begin
        if (act.right) begin
          s_d.set.aspect = (s_q.set.aspect == ASP_MANUAL) ? ASP_16X9 :
                           aspect_e'(s_q.set.aspect + 2'h1);
        end else if (act.left) begin
          s_d.set.aspect = (s_q.set.aspect == ASP_16X9) ? ASP_MANUAL :
                           aspect_e'(s_q.set.aspect - 2'h1);
        end else if (act.def_h) begin
          s_d.set.aspect = ASP_16X9;
        end
      end
      CTL_BORDER: begin
        if (act.right && s_q.set.border != BORDER_MAX) begin
          s_d.set.border = s_q.set.border + 1'b1;
        end else if (act.left && s_q.set.border != 4'h0) begin
          s_d.set.border = s_q.set.border - 1'b1;
        end else if (act.def_h) begin
          s_d.set.border = BORDER_RST;
        end
      end
      CTL_SHARP: begin
        if (act.right && s_q.set.sharp != SHARP_MAX) begin
          s_d.set.sharp = s_q.set.sharp + 1'b1;
        end else if (act.left && s_q.set.sharp != SHARP_MIN) begin
          s_d.set.sharp = s_q.set.sharp - 1'b1;
        end else if (act.def_h) begin
          s_d.set.sharp = SHARP_RST;
        end
      end
      CTL_BARS: begin
        if (act.right || act.left) begin
          s_d.set.bars = ~s_q.set.bars;
        end else if (act.def_h) begin
          s_d.set.bars = BARS_RST;
        end
      end
      default: begin
        s_d.ctl = CTL_INPUT;
      end
    endcase
    if (act.maxim && (s_q.ctl == CTL_POS || s_q.ctl == CTL_SIZE)) begin
      s_d.reg_r = '{x0: COORD_ZERO, y0: COORD_ZERO,
                    x1: mw - 1'b1, y1: mh - 1'b1};
    end
    // Corner clamp; a shrinking raster pulls the region in with it.
    if (s_d.reg_r.x1 > rw - 1'b1) begin
      s_d.reg_r.x1 = rw - 1'b1;
    end
    if (s_d.reg_r.y1 > rh - 1'b1) begin
      s_d.reg_r.y1 = rh - 1'b1;
    end
    if (s_d.reg_r.x0 >= s_d.reg_r.x1) begin
      s_d.reg_r.x0 = s_d.reg_r.x1 - 1'b1;
    end
    if (s_d.reg_r.y0 >= s_d.reg_r.y1) begin
      s_d.reg_r.y0 = s_d.reg_r.y1 - 1'b1;
    end
    if (s_q.blink_cnt == CNT_W'(BLK_CYC - 1)) begin
      s_d.blink_cnt = '0;
      s_d.blink_on = ~s_q.blink_on;
    end else begin
      s_d.blink_cnt = s_q.blink_cnt + 1'b1;
    end
    for (int i = 0; i < NUM_CTL; i++) begin
      if (s_d.ctl == 4'(i) && !s_d.blink_on) begin
        s_d.green[i] = 1'b0;
        s_d.orange[i] = 1'b0;
      end else begin
        s_d.green[i] = dflt[i];
        s_d.orange[i] = ~dflt[i];
      end
    end
    hd = (s_d.set.mode != MODE_SD);
    s_d.dig = (s_d.set.input_sel == IN_AUTO) ? (in_valid & in_digital) :
              (s_d.set.input_sel == IN_DIGITAL);
    s_d.ana = (s_d.set.input_sel == IN_AUTO) ? (in_valid & ~in_digital) :
              (s_d.set.input_sel == IN_ANALOG);
    s_d.ntsc = ~s_d.set.std_pal;
    s_d.pal = s_d.set.std_pal;
    s_d.mode_led = {s_d.set.mode == MODE_720P, s_d.set.mode == MODE_1080I,
                    s_d.set.mode == MODE_SD};
    s_d.inv = in_valid;
    s_d.refl = ref_valid & ref_locked;
    s_d.pillar = hd && (s_d.set.aspect == ASP_4X3);
    s_d.letter = !hd && (s_d.set.aspect == ASP_16X9);
    s_d.genlock = ref_valid & ref_locked;
    s_d.ofs = s_d.genlock ? timing_offset : '0;
  end

  // Default-value flags, one per control, in control order.
  always_comb begin
    dflt = '0;
    dflt[CTL_INPUT] = (s_d.set.input_sel == IN_AUTO);
    dflt[CTL_STD] = (s_d.set.std_pal == STD_PAL_RST);
    dflt[CTL_MODE] = (s_d.set.mode == MODE_SD);
    dflt[CTL_POS] = (s_d.reg_r.x0 == COORD_ZERO) &&
                    (s_d.reg_r.y0 == COORD_ZERO);
    dflt[CTL_SIZE] = (s_d.reg_r.x1 == rw - 1'b1) &&
                     (s_d.reg_r.y1 == rh - 1'b1);
    dflt[CTL_ASPECT] = (s_d.set.aspect == ASP_16X9);
    dflt[CTL_BORDER] = (s_d.set.border == BORDER_RST);
    dflt[CTL_SHARP] = (s_d.set.sharp == SHARP_RST);
    dflt[CTL_BARS] = (s_d.set.bars == BARS_RST);
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '{ctl: CTL_INPUT,
               set: '{input_sel: IN_AUTO, std_pal: STD_PAL_RST,
                      mode: MODE_SD, aspect: ASP_16X9, border: BORDER_RST,
                      sharp: SHARP_RST, bars: BARS_RST},
               reg_r: '{x0: COORD_ZERO, y0: COORD_ZERO,
                        x1: COORD_MAX, y1: COORD_MAX},
               blink_on: 1'b1,
               default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign ctl_led_green = s_q.green;
  assign ctl_led_orange = s_q.orange;
  assign led_digital = s_q.dig;
  assign led_analog = s_q.ana;
  assign led_ntsc = s_q.ntsc;
  assign led_pal = s_q.pal;
  assign led_mode = s_q.mode_led;
  assign led_in_valid = s_q.inv;
  assign led_ref = s_q.refl;
  assign settings = s_q.set;
  assign region = s_q.reg_r;
  assign pillar_box = s_q.pillar;
  assign letter_box = s_q.letter;
  assign sdi_bars = s_q.set.bars;
  assign tone_1k_en = s_q.set.bars;
  assign cvbs_copy_sd = (s_q.set.mode == MODE_SD);
  assign cvbs_black = (s_q.set.mode != MODE_SD);
  assign genlock_en = s_q.genlock;
  assign out_offset = s_q.ofs;

endmodule
`default_nettype wire

//--- src/panel_pkg.sv
// Shared constants, field layouts and carriers for the front panel logic.
// Assumes a single 10 MHz system clock and a synchronous active-high reset.
package panel_pkg;

  localparam int CLK_HZ = 10_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;

  // Times in milliseconds, and the cycle counts derived from them.
  localparam int DEBOUNCE_MS = 10;
  localparam int COINCIDE_MS = 60;
  localparam int BLINK_MS = 250;
  localparam int RPT_FIRST_MS = 500;
  localparam int RPT_SLOW_MS = 150;
  localparam int RPT_FAST_MS = 40;
  localparam int DEBOUNCE_CYC = DEBOUNCE_MS * CYC_PER_MS;
  localparam int COINCIDE_CYC = COINCIDE_MS * CYC_PER_MS;
  localparam int BLINK_CYC = BLINK_MS * CYC_PER_MS;
  localparam int RPT_FIRST_CYC = RPT_FIRST_MS * CYC_PER_MS;
  localparam int RPT_SLOW_CYC = RPT_SLOW_MS * CYC_PER_MS;
  localparam int RPT_FAST_CYC = RPT_FAST_MS * CYC_PER_MS;
  localparam logic [3:0] RPT_SPEEDUP = 4'h8;
  localparam int CNT_W = 24;

  // Button bit positions.
  localparam int NUM_BTN = 6;
  localparam int BTN_PREV = 0;
  localparam int BTN_NEXT = 1;
  localparam int BTN_LEFT = 2;
  localparam int BTN_RIGHT = 3;
  localparam int BTN_UP = 4;
  localparam int BTN_DOWN = 5;

  // Panel control list, in stepping order.
  localparam int NUM_CTL = 9;
  localparam logic [3:0] CTL_INPUT = 4'h0;
  localparam logic [3:0] CTL_STD = 4'h1;
  localparam logic [3:0] CTL_MODE = 4'h2;
  localparam logic [3:0] CTL_POS = 4'h3;
  localparam logic [3:0] CTL_SIZE = 4'h4;
  localparam logic [3:0] CTL_ASPECT = 4'h5;
  localparam logic [3:0] CTL_BORDER = 4'h6;
  localparam logic [3:0] CTL_SHARP = 4'h7;
  localparam logic [3:0] CTL_BARS = 4'h8;
  localparam logic [3:0] CTL_LAST = 4'h8;

  typedef enum logic [1:0] {
    IN_AUTO = 2'h0,
    IN_DIGITAL = 2'h1,
    IN_ANALOG = 2'h2
  } input_sel_e;

  typedef enum logic [1:0] {
    MODE_SD = 2'h0,
    MODE_1080I = 2'h1,
    MODE_720P = 2'h2
  } out_mode_e;

  typedef enum logic [1:0] {
    ASP_16X9 = 2'h0,
    ASP_4X3 = 2'h1,
    ASP_MANUAL = 2'h2
  } aspect_e;

  localparam int COORD_W = 12;
  localparam logic [3:0] BORDER_MAX = 4'hf;
  localparam logic [3:0] BORDER_RST = 4'h0;
  localparam logic [3:0] SHARP_MIN = 4'h1;
  localparam logic [3:0] SHARP_MAX = 4'h8;
  localparam logic [3:0] SHARP_RST = 4'h4;
  localparam logic STD_PAL_RST = 1'b0;
  localparam logic BARS_RST = 1'b0;
  localparam logic [COORD_W-1:0] COORD_ZERO = 12'h000;
  localparam logic [COORD_W-1:0] COORD_MAX = 12'hfff;

  typedef struct packed {
    logic prev;
    logic next;
    logic left;
    logic right;
    logic up;
    logic down;
    logic def_h;
    logic def_v;
    logic maxim;
  } action_s;

  typedef struct packed {
    input_sel_e input_sel;
    logic std_pal;
    out_mode_e mode;
    aspect_e aspect;
    logic [3:0] border;
    logic [3:0] sharp;
    logic bars;
  } settings_s;

  typedef struct packed {
    logic [COORD_W-1:0] x0;
    logic [COORD_W-1:0] y0;
    logic [COORD_W-1:0] x1;
    logic [COORD_W-1:0] y1;
  } region_s;

endpackage

//--- src/button_debounce.sv
// Debounces a group of push buttons; each output level changes only after
// its raw input has held a new level for DEB_CYC cycles.
// Assumes the raw button levels are already synchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module button_debounce import panel_pkg::*; #(
  parameter int N = NUM_BTN,
  parameter int DEB_CYC = DEBOUNCE_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [N-1:0] raw,
  output logic [N-1:0] level
);

  typedef struct packed {
    logic [N-1:0] lvl;
    logic [N-1:0][CNT_W-1:0] cnt;
  } deb_state_s;

  deb_state_s s_q;
  deb_state_s s_d;

  always_comb begin
    s_d = s_q;
    for (int i = 0; i < N; i++) begin
      if (raw[i] == s_q.lvl[i]) begin
        s_d.cnt[i] = '0;
      end else if (s_q.cnt[i] == CNT_W'(DEB_CYC - 1)) begin
        s_d.lvl[i] = raw[i];
        s_d.cnt[i] = '0;
      end else begin
        s_d.cnt[i] = s_q.cnt[i] + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level = s_q.lvl;

endmodule
`default_nettype wire

//--- src/press_engine.sv
// Turns debounced button levels into one-cycle action pulses: it gathers
// presses over a coincidence window, decodes combinations, and repeats a
// single held arrow at a rate that rises with the hold time.
// Assumes debounced, active-high button levels.
`timescale 1ns/1ps
`default_nettype none
module press_engine import panel_pkg::*; #(
  parameter int WIN_CYC = COINCIDE_CYC,
  parameter int FIRST_CYC = RPT_FIRST_CYC,
  parameter int SLOW_CYC = RPT_SLOW_CYC,
  parameter int FAST_CYC = RPT_FAST_CYC
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [NUM_BTN-1:0] btn,
  output action_s act
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_GATHER = 3'b010,
    ST_HELD = 3'b100
  } press_st_e;

  typedef struct packed {
    press_st_e st;
    logic [NUM_BTN-1:0] acc;
    logic [CNT_W-1:0] cnt;
    logic [3:0] nrep;
    action_s act;
  } press_state_s;

  press_state_s s_q;
  press_state_s s_d;

  function automatic action_s decode(input logic [NUM_BTN-1:0] b);
    action_s a;
    a = '0;
    if (b[BTN_UP] && b[BTN_LEFT] && b[BTN_RIGHT]) begin
      a.maxim = 1'b1;
    end else if (b[BTN_LEFT] && b[BTN_RIGHT]) begin
      a.def_h = 1'b1;
    end else if (b[BTN_UP] && b[BTN_DOWN]) begin
      a.def_v = 1'b1;
    end else if ($onehot(b)) begin
      a.prev = b[BTN_PREV];
      a.next = b[BTN_NEXT];
      a.left = b[BTN_LEFT];
      a.right = b[BTN_RIGHT];
      a.up = b[BTN_UP];
      a.down = b[BTN_DOWN];
    end
    return a;
  endfunction

  logic [CNT_W-1:0] limit;
  logic arrow_held;

  always_comb begin
    s_d = s_q;
    s_d.act = '0;
    limit = CNT_W'(FAST_CYC - 1);
    if (s_q.nrep == 4'h0) begin
      limit = CNT_W'(FIRST_CYC - 1);
    end else if (s_q.nrep < RPT_SPEEDUP) begin
      limit = CNT_W'(SLOW_CYC - 1);
    end
    arrow_held = $onehot(s_q.acc) && (btn == s_q.acc) &&
                 (s_q.acc[BTN_PREV] == 1'b0) && (s_q.acc[BTN_NEXT] == 1'b0);
    case (s_q.st)
      ST_IDLE: begin
        if (|btn) begin
          s_d.st = ST_GATHER;
          s_d.acc = btn;
          s_d.cnt = '0;
        end
      end
      ST_GATHER: begin
        s_d.acc = s_q.acc | btn;
        s_d.cnt = s_q.cnt + 1'b1;
        if (s_q.cnt == CNT_W'(WIN_CYC - 1)) begin
          s_d.act = decode(s_d.acc);
          s_d.st = ST_HELD;
          s_d.cnt = '0;
          s_d.nrep = 4'h0;
        end
      end
      ST_HELD: begin
        if (btn == '0) begin
          s_d.st = ST_IDLE;
          s_d.acc = '0;
        end else if (arrow_held) begin
          s_d.cnt = s_q.cnt + 1'b1;
          if (s_q.cnt == limit) begin
            s_d.act = decode(s_q.acc);
            s_d.cnt = '0;
            if (s_q.nrep != RPT_SPEEDUP) begin
              s_d.nrep = s_q.nrep + 1'b1;
            end
          end
        end
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '{st: ST_IDLE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  assign act = s_q.act;

endmodule
`default_nettype wire

//--- verification/panel_monitor.sv
// Checker for the front panel controller, bound onto its top ports.
// Assumes the synchronous active-high reset and one clock.
`timescale 1ns/1ps
`default_nettype none
module panel_monitor import panel_pkg::*; #(
  parameter int OFS_W = 20
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic panel_locked,
  input wire logic in_valid,
  input wire logic ref_valid,
  input wire logic ref_locked,
  input wire logic [NUM_CTL-1:0] ctl_led_green,
  input wire logic [NUM_CTL-1:0] ctl_led_orange,
  input wire logic led_ntsc,
  input wire logic led_pal,
  input wire logic [2:0] led_mode,
  input wire logic led_in_valid,
  input wire logic led_ref,
  input wire settings_s settings,
  input wire region_s region,
  input wire logic sdi_bars,
  input wire logic tone_1k_en,
  input wire logic cvbs_copy_sd,
  input wire logic cvbs_black,
  input wire logic genlock_en,
  input wire logic [OFS_W-1:0] out_offset
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Lamp registers hold zero through reset, so their checks wait one edge.
  logic live_q;
  always_ff @(posedge ref_clk) begin
    live_q <= !rst;
  end
  std_lamp_a: assert property (live_q |-> led_pal == settings.std_pal
    && led_ntsc == !settings.std_pal) else $error("standard lamp wrong");
  mode_lamp_a: assert property (live_q |->
    led_mode == 3'h1 << settings.mode) else $error("mode lamp wrong");
  cvbs_follow_a: assert property (cvbs_copy_sd == (settings.mode == MODE_SD)
    && cvbs_black != cvbs_copy_sd) else $error("composite select wrong");
  bars_out_a: assert property (sdi_bars == settings.bars
    && tone_1k_en == settings.bars) else $error("bars output wrong");
  sharp_range_a: assert property (settings.sharp inside
    {[SHARP_MIN:SHARP_MAX]}) else $error("sharpness out of range");
  corner_order_a: assert property (live_q |-> region.x0 < region.x1
    && region.y0 < region.y1) else $error("region corners crossed");
  in_lamp_a: assert property (1'b1 |=>
    led_in_valid == $past(in_valid)) else $error("input lamp wrong");
  ref_lamp_a: assert property (ref_valid && ref_locked |=>
    led_ref && genlock_en) else $error("reference lamp not lit");
  free_run_a: assert property (live_q && !genlock_en |->
    out_offset == '0) else $error("offset without reference");
  led_color_a: assert property (live_q |->
    (ctl_led_green & ctl_led_orange) == '0) else $error("lamp both colors");
  lock_hold_a: assert property (panel_locked ##1 panel_locked |=>
    $stable(settings)) else $error("settings moved while locked");
  cover property (settings.std_pal);
  cover property (settings.mode == MODE_720P);
  cover property (settings.bars);
endmodule
`default_nettype wire

//--- verification/button_user.sv
// Model of a user at the six panel buttons.
// Assumes the caller waits for each press to finish before the next.
`timescale 1ns/1ps
`default_nettype none
module button_user (
  input wire logic ref_clk,
  output logic [5:0] btn_raw
);
  initial btn_raw = 6'h00;
  // Holds a mask for h cycles, lets go and waits out the debounce.
  task automatic push(input logic [5:0] m, input int h);
    @(negedge ref_clk);
    btn_raw = m;
    repeat (h) @(negedge ref_clk);
    btn_raw = 6'h00;
    repeat (16) @(negedge ref_clk);
  endtask
endmodule
`default_nettype wire

//--- verification/front_panel_controller_tb.sv
// Self-checking bench for the front panel controller.
// Assumes the shortened timing parameters given to the instance below.
`timescale 1ns/1ps
`default_nettype none
module front_panel_controller_tb import panel_pkg::*;;
  logic ref_clk = 0, rst = 1, panel_locked = 0, in_valid = 0;
  logic in_digital = 0, ref_valid = 0, ref_locked = 0;
  logic [11:0] raster_w = 12'h280, raster_h = 12'h1e0;
  logic [19:0] timing_offset = 20'h12345, out_offset;
  wire logic [5:0] btn_raw;
  logic led_digital, led_analog, led_pal, led_ref, sdi_bars, cvbs_black;
  settings_s settings;
  region_s region;
  logic [8:0] grn, org;
  logic pillar, letter;
  int err_count = 0, checked = 0, dark = 0;
  button_user user (.ref_clk(ref_clk), .btn_raw(btn_raw));
  front_panel_controller #(.DEB_CYC(4), .WIN_CYC(4), .BLK_CYC(8),
    .FIRST_CYC(20), .SLOW_CYC(10), .FAST_CYC(5)) uut (
    .ref_clk(ref_clk), .rst(rst), .btn_raw(btn_raw),
    .panel_locked(panel_locked), .in_valid(in_valid),
    .in_digital(in_digital), .raster_w(raster_w), .raster_h(raster_h),
    .ref_valid(ref_valid), .ref_locked(ref_locked),
    .timing_offset(timing_offset), .ctl_led_green(grn), .ctl_led_orange(org),
    .led_digital(led_digital), .led_analog(led_analog), .led_ntsc(),
    .led_pal(led_pal), .led_mode(), .led_in_valid(), .led_ref(led_ref),
    .settings(settings), .region(region), .pillar_box(pillar),
    .letter_box(letter),
    .sdi_bars(sdi_bars), .tone_1k_en(), .cvbs_copy_sd(),
    .cvbs_black(cvbs_black), .genlock_en(), .out_offset(out_offset));
  initial forever #50 ref_clk = ~ref_clk;
  task chk(input string n, input logic [47:0] e, input logic [47:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_count++;
    complete_run();
  end
  initial begin
    repeat (6) @(negedge ref_clk);
    rst = 0;
    repeat (2) @(negedge ref_clk);
    chk("settings", {IN_AUTO, STD_PAL_RST, MODE_SD, ASP_16X9, BORDER_RST,
      SHARP_RST, BARS_RST}, settings);
    chk("region", {24'h0, 12'h27f, 12'h1df}, region);
    chk("lamps", {9'h1ff, 9'h000}, {grn, org});
    chk("boxes", 2'b01, {pillar, letter});
    repeat (16) begin
      @(negedge ref_clk);
      dark += (grn[0] == 1'b0 && org[0] == 1'b0);
    end
    chk("blink", 8, dark);
    $display("test reset done");
    user.push(6'h02, 14);
    user.push(6'h08, 14);
    chk("pal", 2'b11, {settings.std_pal, led_pal});
    user.push(6'h0c, 14);
    chk("ntsc", 1'b0, settings.std_pal);
    repeat (2) user.push(6'h01, 14);
    user.push(6'h08, 14);
    chk("bars", 2'b11, {settings.bars, sdi_bars});
    user.push(6'h01, 14);
    chk("bars lamp", 2'b01, {grn[8], org[8]});
    user.push(6'h08, 32);
    chk("sharp repeat", 4'h6, settings.sharp);
    user.push(6'h08, 120);
    chk("sharp top", SHARP_MAX, settings.sharp);
    user.push(6'h0c, 14);
    chk("sharp default", SHARP_RST, settings.sharp);
    $display("test controls done");
    repeat (4) user.push(6'h01, 14);
    user.push(6'h08, 14);
    user.push(6'h20, 14);
    chk("position", 24'h001001, region[47:24]);
    user.push(6'h0c, 14);
    chk("h default", 24'h000001, region[47:24]);
    user.push(6'h30, 14);
    chk("v default", 24'h0, region[47:24]);
    user.push(6'h02, 14);
    user.push(6'h04, 14);
    chk("size", 12'h27e, region.x1);
    user.push(6'h1c, 14);
    chk("maximize", {24'h0, 12'h27f, 12'h167}, region);
    raster_w = 12'h100;
    raster_h = 12'h080;
    repeat (2) @(negedge ref_clk);
    chk("shrink", {24'h0, 12'h0ff, 12'h07f}, region);
    $display("test region done");
    repeat (2) user.push(6'h01, 14);
    for (int i = 1; i < 4; i++) begin
      user.push(6'h08, 14);
      chk("mode", {2'(i % 3), i % 3 != 0}, {settings.mode, cvbs_black});
      chk("letter", i % 3 == 0, letter);
    end
    panel_locked = 1;
    user.push(6'h08, 14);
    chk("locked", MODE_SD, settings.mode);
    panel_locked = 0;
    user.push(6'h08, 2);
    chk("glitch", MODE_SD, settings.mode);
    $display("test mode done");
    ref_valid = 1;
    ref_locked = 1;
    in_valid = 1;
    in_digital = 1;
    repeat (3) @(negedge ref_clk);
    chk("ref", {1'b1, 20'h12345}, {led_ref, out_offset});
    chk("digital", 2'b10, {led_digital, led_analog});
    in_digital = 0;
    ref_locked = 0;
    timing_offset = 20'h00abc;
    repeat (3) @(negedge ref_clk);
    chk("analog", 3'b010, {led_digital, led_analog, led_ref});
    chk("free run", 20'h0, out_offset);
    ref_locked = 1;
    repeat (2) @(negedge ref_clk);
    chk("offset", 20'h00abc, out_offset);
    $display("test status done");
    complete_run();
  end
endmodule
bind front_panel_controller panel_monitor #(.OFS_W(OFS_W)) mon (.*);
`default_nettype wire
